// ===== src/gpf_pkg.sv
package gpf_pkg;
   // ************************************************************
   // Bus and port geometry
   // ************************************************************
   localparam int ADDR_W = 13;
   localparam int IDX_W = 11;
   localparam int NPORT = 11;
   localparam int PW = 8;

   // Port slots inside the packed pin vectors
   localparam int P2 = 0;
   localparam int P3 = 1;
   localparam int P4 = 2;
   localparam int P5 = 3;
   localparam int P6 = 4;
   localparam int P7 = 5;
   localparam int P8 = 6;
   localparam int PA = 7;
   localparam int PB = 8;
   localparam int PE = 9;
   localparam int PF = 10;

   // Implemented bits per port, slot 10 (F) down to slot 0 (2)
   localparam logic [NPORT-1:0][PW-1:0] PORT_MASK = {
      8'hff, 8'hff, 8'hff, 8'h7f, 8'h3f, 8'h01,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

   // ************************************************************
   // Register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [NPORT-1:0][IDX_W-1:0] DATA_IDX = {
      11'h013, 11'h012, 11'h008, 11'h009, 11'h00b, 11'h004,
      11'h005, 11'h006, 11'h007, 11'h000, 11'h001};
   localparam logic [NPORT-1:0][IDX_W-1:0] DIR_IDX = {
      11'h0d3, 11'h0d2, 11'h608, 11'h609, 11'h60b, 11'h604,
      11'h605, 11'h606, 11'h607, 11'h600, 11'h601};
   localparam logic [IDX_W-1:0] IDX_EXT_PIN_CTRL1 = 11'h700;
   localparam logic [IDX_W-1:0] IDX_XFER_PIN_CTRL = 11'h701;
   localparam logic [IDX_W-1:0] IDX_BUS_CONFIG = 11'h702;
   localparam logic [IDX_W-1:0] IDX_PIN_STATUS = 11'h703;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int EP1_AE_LSB = 0;
   localparam int EP1_ADDRESS_BIT24_ENABLE_BIT = 8;
   localparam int XP_SRC0_BIT = 0;
   localparam int XP_DST0_BIT = 1;
   localparam int BC_MODE_LSB = 0;
   localparam int BC_AREA_LSB = 2;
   localparam int ST_EXT_BIT = 0;
   localparam int ST_WIDE_BIT = 1;
   localparam logic [PW-1:0] DIR_RESET = 8'h00;
   localparam logic [8:0] EP1_RESET = 9'h000;
   localparam logic [1:0] XP_RESET = 2'h0;
   localparam logic [7:0] BC_RESET = 8'h00;

   // Mode encodings
   localparam logic [2:0] MD_SINGLE_CHIP = 3'h0;
   localparam logic [1:0] BM_FOLLOW_PINS = 2'h0;
   localparam logic [2:0] P7_SEL_PORT = 3'h0;
   localparam logic [2:0] P7_SEL_ADDR24 = 3'h4;
endpackage

// ===== src/gpf_port_top.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - Input bit: data read returns pin level
// - Input bit: data write stores, pin undriven
// - Output bit: data read returns stored latch
// - Output bit: data write drives the pin
// - Each direction bit: 0 input, 1 output
// - Claimed pin goes to resource, else port
// - Port 2: data 16-23 on 16-bit bus
// - Port 3: data 24-31 in external mode
// - Ports 4,5: address 0-15 in external mode
// - Bus pins chosen from mode pins, settings
// - Port 6 bit-wise: enable picks address 16-23
// - Port 7 bit 0: port, address 24, end-of-transfer
// - Data latches unreset; absent bits not stored
module gpf_port_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [gpf_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] operating_mode_pins,
   input wire logic [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] port_pin_in,
   output logic [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] port_pin_out,
   output logic [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] port_pin_oe,
   input wire logic [31:16] bus_data_out,
   input wire logic bus_data_oe,
   output logic [31:16] bus_data_in,
   input wire logic [24:0] bus_address,
   input wire logic bus_address_oe,
   input wire logic end_of_transfer_out_0
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [2:0] md_s1_r;
   logic [2:0] md_s2_r;
   logic [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] pin_s1_r;
   logic [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] pin_s2_r;

   // Mode pins are asynchronous to pclk, two stages before any use
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         md_s1_r <= 3'h0;
         md_s2_r <= 3'h0;
      end
      else
      begin
         md_s1_r <= operating_mode_pins;
         md_s2_r <= md_s1_r;
      end
   end

   // Port pins likewise; only the second stage feeds logic
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end
      else
      begin
         pin_s1_r <= port_pin_in;
         pin_s2_r <= pin_s1_r;
      end
   end

   // ************************************************************
   // APB access decode
   // ************************************************************
   logic [gpf_pkg::IDX_W-1:0] idx;
   logic access;
   logic wr_en;
   logic [gpf_pkg::NPORT-1:0] hit_data;
   logic [gpf_pkg::NPORT-1:0] hit_dir;
   logic hit_own;

   // Word index; byte lanes ignored, one register per word
   assign idx = paddr[gpf_pkg::ADDR_W-1:2];
   assign access = psel & penable & pready;
   assign wr_en = access & pwrite;

   // Per-port address match
   always_comb
   begin
      hit_data = '0;
      hit_dir = '0;
      for (int p = 0; p < gpf_pkg::NPORT; p++)
      begin
         hit_data[p] = (idx == gpf_pkg::DATA_IDX[p]);
         hit_dir[p] = (idx == gpf_pkg::DIR_IDX[p]);
      end
   end

   // Own control registers, one strobe each
   logic hit_ep1;
   logic hit_xp;
   logic hit_bc;
   logic hit_st;
   logic mapped;

   assign hit_ep1 = (idx == gpf_pkg::IDX_EXT_PIN_CTRL1);
   assign hit_xp = (idx == gpf_pkg::IDX_XFER_PIN_CTRL);
   assign hit_bc = (idx == gpf_pkg::IDX_BUS_CONFIG);
   assign hit_st = (idx == gpf_pkg::IDX_PIN_STATUS);
   // Status is read-only but still mapped, so it raises no error
   assign hit_own = hit_ep1 | hit_xp | hit_bc | hit_st;

   // Any known index; everything else answers with an error
   assign mapped = (|hit_data) | (|hit_dir) | hit_own;

   // ************************************************************
   // Port data latches and direction registers
   // ************************************************************
   wire [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] latch;
   wire [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] dir;

   genvar gp;
   genvar gb;
   generate
      for (gp = 0; gp < gpf_pkg::NPORT; gp++)
      begin : g_port
         for (gb = 0; gb < gpf_pkg::PW; gb++)
         begin : g_bit
            if (gpf_pkg::PORT_MASK[gp][gb])
            begin : g_impl
               logic latch_q;
               logic dir_q;
               // Latch holds no reset value; stored in either direction
               always_ff @(posedge pclk)
               begin
                  if (wr_en && hit_data[gp])
                     latch_q <= pwdata[gb];
               end
               // Direction bit, one per pin
               always_ff @(posedge pclk or negedge presetn)
               begin
                  if (!presetn)
                     dir_q <= gpf_pkg::DIR_RESET[gb];
                  else if (wr_en && hit_dir[gp])
                     dir_q <= pwdata[gb];
               end
               assign latch[gp][gb] = latch_q;
               assign dir[gp][gb] = dir_q;
            end
            else
            begin : g_absent
               // No storage behind bits the port lacks
               assign latch[gp][gb] = 1'b0;
               assign dir[gp][gb] = 1'b0;
            end
         end
      end
   endgenerate

   // ************************************************************
   // Pin function control registers
   // ************************************************************
   logic [8:0] ext_pin_ctrl1_r;
   logic [1:0] xfer_pin_ctrl_r;
   logic [7:0] bus_config_r;

   // Address enables for ports 6 and 7
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ext_pin_ctrl1_r <= gpf_pkg::EP1_RESET;
      else if (wr_en && hit_ep1)
         ext_pin_ctrl1_r <= pwdata[8:0];
   end

   // End-of-transfer source and destination enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         xfer_pin_ctrl_r <= gpf_pkg::XP_RESET;
      else if (wr_en && hit_xp)
         xfer_pin_ctrl_r <= pwdata[1:0];
   end

   // Bus mode bits and area width settings
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bus_config_r <= gpf_pkg::BC_RESET;
      else if (wr_en && hit_bc)
         bus_config_r <= pwdata[7:0];
   end

   // ************************************************************
   // Operating mode and pin ownership
   // ************************************************************
   logic ext_bus;
   logic wide_bus;
   logic [2:0] p7_sel;
   logic [7:0] upper_address_enable_bits;
   logic p7_addr24;
   logic p7_eot;

   // Bus pins follow mode pins, bus mode bits and area widths only
   assign ext_bus = (md_s2_r != gpf_pkg::MD_SINGLE_CHIP) |
      (bus_config_r[gpf_pkg::BC_MODE_LSB +: 2] !=
       gpf_pkg::BM_FOLLOW_PINS);
   // Wide only when some area asks for a 16-bit bus
   assign wide_bus = ext_bus &
      (|bus_config_r[gpf_pkg::BC_AREA_LSB +: 6]);
   // Port 6 enables sit in the low byte
   assign upper_address_enable_bits =
      ext_pin_ctrl1_r[gpf_pkg::EP1_AE_LSB +: 8];
   // Select bits ordered address, source, destination
   assign p7_sel = {ext_pin_ctrl1_r[gpf_pkg::EP1_ADDRESS_BIT24_ENABLE_BIT],
                    xfer_pin_ctrl_r[gpf_pkg::XP_SRC0_BIT],
                    xfer_pin_ctrl_r[gpf_pkg::XP_DST0_BIT]};
   // All clear keeps the port; only 100 picks the address
   assign p7_addr24 = (p7_sel == gpf_pkg::P7_SEL_ADDR24);
   assign p7_eot = (p7_sel != gpf_pkg::P7_SEL_PORT) & ~p7_addr24;

   logic [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] own;
   logic [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] res_out;
   logic [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] res_oe;

   // Resource claims per pin; unclaimed pins stay ports
   always_comb
   begin
      own = '0;
      res_out = '0;
      res_oe = '0;
      // Port 2 carries data only on a wide bus
      if (wide_bus)
      begin
         own[gpf_pkg::P2] = 8'hff;
         res_out[gpf_pkg::P2] = bus_data_out[23:16];
         res_oe[gpf_pkg::P2] = {8{bus_data_oe}};
      end
      // Port 3 data, ports 4 and 5 low address
      if (ext_bus)
      begin
         own[gpf_pkg::P3] = 8'hff;
         res_out[gpf_pkg::P3] = bus_data_out[31:24];
         res_oe[gpf_pkg::P3] = {8{bus_data_oe}};
         own[gpf_pkg::P4] = 8'hff;
         own[gpf_pkg::P5] = 8'hff;
         res_out[gpf_pkg::P4] = bus_address[7:0];
         res_out[gpf_pkg::P5] = bus_address[15:8];
         res_oe[gpf_pkg::P4] = {8{bus_address_oe}};
         res_oe[gpf_pkg::P5] = {8{bus_address_oe}};
      end
      // Port 6 switches bit by bit, whatever the mode
      own[gpf_pkg::P6] = upper_address_enable_bits;
      res_out[gpf_pkg::P6] = bus_address[23:16];
      res_oe[gpf_pkg::P6] = {8{bus_address_oe}};
      // Any enable pattern other than the two named gives EOT out
      if (p7_addr24)
      begin
         own[gpf_pkg::P7][0] = 1'b1;
         res_out[gpf_pkg::P7][0] = bus_address[24];
         res_oe[gpf_pkg::P7][0] = bus_address_oe;
      end
      else if (p7_eot)
      begin
         own[gpf_pkg::P7][0] = 1'b1;
         res_out[gpf_pkg::P7][0] = end_of_transfer_out_0;
         res_oe[gpf_pkg::P7][0] = 1'b1;
      end
   end

   // ************************************************************
   // Pin drivers
   // ************************************************************
   logic [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] pin_out_nxt;
   logic [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] pin_oe_nxt;

   // Unclaimed pins carry the latch in either direction; the enable below gates the drive
   assign pin_out_nxt = ((own & res_out) | (~own & latch)) &
                        gpf_pkg::PORT_MASK;
   // Enable follows the owner, else the direction bit
   assign pin_oe_nxt = ((own & res_oe) | (~own & dir)) &
                       gpf_pkg::PORT_MASK;

   // Registered so pins never glitch on decode changes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_pin_out <= '0;
         port_pin_oe <= '0;
      end
      else
      begin
         port_pin_out <= pin_out_nxt;
         port_pin_oe <= pin_oe_nxt;
      end
   end

   // Incoming bus data, already two stages from the pins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bus_data_in <= '0;
      else
         bus_data_in <= {pin_s2_r[gpf_pkg::P3], pin_s2_r[gpf_pkg::P2]};
   end

   // ************************************************************
   // Read data and handshake
   // ************************************************************
   logic [31:0] rdata_nxt;
   logic [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] port_view;

   // Output bits show the latch, input bits the synced pin
   assign port_view = ((dir & latch) | (~dir & pin_s2_r)) &
                      gpf_pkg::PORT_MASK;

   // Direction registers are write-only and read as zero
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      for (int p = 0; p < gpf_pkg::NPORT; p++)
      begin
         if (hit_data[p])
            rdata_nxt[7:0] = port_view[p];
      end
      if (idx == gpf_pkg::IDX_EXT_PIN_CTRL1)
         rdata_nxt[8:0] = ext_pin_ctrl1_r;
      if (idx == gpf_pkg::IDX_XFER_PIN_CTRL)
         rdata_nxt[1:0] = xfer_pin_ctrl_r;
      if (idx == gpf_pkg::IDX_BUS_CONFIG)
         rdata_nxt[7:0] = bus_config_r;
      if (idx == gpf_pkg::IDX_PIN_STATUS)
      begin
         rdata_nxt[gpf_pkg::ST_EXT_BIT] = ext_bus;
         rdata_nxt[gpf_pkg::ST_WIDE_BIT] = wide_bus;
      end
   end

   // No wait state: ready rises the cycle after setup, for one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= psel & ~penable & ~pready;
   end

   // Error flags an unmapped index alongside ready
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr <= 1'b0;
      else
         pslverr <= psel & ~penable & ~mapped;
   end

   // Data captured at setup and held until the next setup
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable)
         prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
   end
endmodule

// ===== test/gpf_port_checker.sv
`timescale 1ns/1ps
module gpf_port_checker
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [gpf_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] operating_mode_pins,
   input wire logic [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] port_pin_out,
   input wire logic [gpf_pkg::NPORT-1:0][gpf_pkg::PW-1:0] port_pin_oe,
   input wire logic [31:16] bus_data_out,
   input wire logic bus_data_oe,
   input wire logic bus_address_oe
);
   // ************************************************************
   // Bus handshake and pin ownership checks
   // ************************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Completed write to one register index
   sequence wr_at(logic [10:0] idx);
      psel && penable && pready && pwrite && paddr[12:2] == idx;
   endsequence
   // Mode pins held long enough to pass the synchronisers
   sequence ext_held;
      (operating_mode_pins == 3'h1) [*5];
   endsequence

   rdy_after_setup_a:
   assert property (psel && !penable |=> pready)
      else $error("ready missing after setup");
   rdy_pulse_a:
   assert property (pready |=> !pready)
      else $error("ready held too long");
   err_with_rdy_a:
   assert property (pslverr |-> pready)
      else $error("error without ready");
   dir_read_zero_a:
   assert property (pready && !pwrite && paddr[12:2] == 11'h600
      |-> prdata == 32'h0) else $error("direction read not zero");
   reset_inputs_a:
   assert property ($rose(presetn) |-> port_pin_oe == '0)
      else $error("pin driven after reset");
   absent_bits_a:
   assert property (port_pin_oe[gpf_pkg::P7][7:1] == 7'h0
      && port_pin_oe[gpf_pkg::P8][7:6] == 2'h0
      && port_pin_oe[gpf_pkg::PA][7] == 1'b0)
      else $error("absent bit driven");
   p8_dir_a:
   assert property (wr_at(11'h60b) |-> ##2 port_pin_oe[gpf_pkg::P8]
      == ($past(pwdata[7:0], 2) & 8'h3f)) else $error("enable mismatch");
   p8_latch_a:
   assert property (wr_at(11'h00b) |-> ##2 port_pin_out[gpf_pkg::P8]
      == ($past(pwdata[7:0], 2) & 8'h3f)) else $error("output mismatch");
   p3_ext_a:
   assert property (ext_held |=> port_pin_oe[gpf_pkg::P3]
      == {8{$past(bus_data_oe)}}
      && port_pin_out[gpf_pkg::P3] == $past(bus_data_out[31:24]))
      else $error("upper data not routed");
   p4_ext_a:
   assert property (ext_held |=> port_pin_oe[gpf_pkg::P4]
      == {8{$past(bus_address_oe)}}) else $error("address not routed");
endmodule

bind gpf_port_top gpf_port_checker gpf_port_checker_inst
(
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .operating_mode_pins, .port_pin_out, .port_pin_oe,
   .bus_data_out, .bus_data_oe, .bus_address_oe
);

// ===== test/test_gpio_port_pin_function_select.sv
`timescale 1ns/1ps
module test_gpio_port_pin_function_select;
   // ************************************************************
   // Signals, design and clock
   // ************************************************************
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic bus_data_oe, bus_address_oe, end_of_transfer_out_0;
   logic [12:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [2:0] operating_mode_pins;
   logic [10:0][7:0] port_pin_in, port_pin_out, port_pin_oe;
   logic [31:16] bus_data_out, bus_data_in;
   logic [24:0] bus_address;
   int num_errors, check_count;

   gpf_port_top gpf_port_top_inst
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .operating_mode_pins, .port_pin_in,
      .port_pin_out, .port_pin_oe, .bus_data_out, .bus_data_oe,
      .bus_data_in, .bus_address, .bus_address_oe,
      .end_of_transfer_out_0
   );
   // Free-running clock
   always #5 pclk = ~pclk;

   // Compare and count
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      check_count++;
      if (s !== x)
      begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, x);
      end
   endtask
   // One APB transfer; every change right after a rising edge
   task automatic apb(input logic w, input logic [10:0] i,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ready and data read at the edge, before the design updates
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge pclk);
      end
      if (n >= 50)
         num_errors++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Report and stop
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      @(negedge pclk);
      chk({31'h0, |port_pin_oe}, 32'h0);
      apb(1'b1, 11'h601, 32'h3c);
      apb(1'b0, 11'h601, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, 11'h600, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, 11'h7ff, 32'h0);
      chk({e, q[30:0]}, 32'h80000000);
   endtask
   // Input then partial output on a port no resource claims
   task automatic t_port();
      apb(1'b1, 11'h00b, 32'h2a);
      apb(1'b1, 11'h60b, 32'h0);
      port_pin_in[gpf_pkg::P8] <= 8'h15;
      repeat (3) @(negedge pclk);
      chk(port_pin_oe[gpf_pkg::P8], 32'h0);
      apb(1'b0, 11'h00b, 32'h0);
      chk(q, 32'h15);
      apb(1'b1, 11'h60b, 32'h0f);
      repeat (2) @(negedge pclk);
      chk(port_pin_oe[gpf_pkg::P8], 32'h0f);
      chk(port_pin_out[gpf_pkg::P8], 32'h2a);
      apb(1'b0, 11'h00b, 32'h0);
      chk(q, 32'h1a);
      apb(1'b1, 11'h00b, 32'hf3);
      repeat (2) @(negedge pclk);
      chk(port_pin_out[gpf_pkg::P8], 32'h33);
   endtask
   // Every select code of the shared bit, then bit-wise upper address
   task automatic t_select();
      apb(1'b1, 11'h604, 32'h0);
      apb(1'b1, 11'h004, 32'h0);
      for (int s = 0; s < 8; s++)
      begin
         apb(1'b1, 11'h700, {23'h0, s[2], 8'h0});
         apb(1'b1, 11'h701, {30'h0, s[0], s[1]});
         repeat (2) @(negedge pclk);
         chk(port_pin_oe[gpf_pkg::P7][0], s != 0);
         chk(port_pin_out[gpf_pkg::P7][0], s != 0 && s != 4);
      end
      apb(1'b1, 11'h701, 32'h0);
      apb(1'b1, 11'h605, 32'h0);
      apb(1'b1, 11'h005, 32'h0);
      apb(1'b1, 11'h700, 32'ha5);
      repeat (2) @(negedge pclk);
      chk(port_pin_oe[gpf_pkg::P6], 32'ha5);
      chk(port_pin_out[gpf_pkg::P6], 32'ha5);
      apb(1'b1, 11'h700, 32'h0);
   endtask
   // Bus modes from pins and from the mode bits
   task automatic t_mode();
      operating_mode_pins <= 3'h1;
      port_pin_in[gpf_pkg::P3] <= 8'h5c;
      port_pin_in[gpf_pkg::P2] <= 8'h96;
      repeat (6) @(negedge pclk);
      chk(port_pin_out[gpf_pkg::P3], 32'hc3);
      chk(bus_data_in, 32'h5c96);
      chk(port_pin_oe[gpf_pkg::P2], 32'h3c);
      chk({port_pin_out[gpf_pkg::P5], port_pin_out[gpf_pkg::P4]},
         32'h1234);
      apb(1'b1, 11'h702, 32'h04);
      repeat (2) @(negedge pclk);
      chk(port_pin_out[gpf_pkg::P2], 32'ha5);
      chk(port_pin_oe[gpf_pkg::P2], 32'hff);
      apb(1'b0, 11'h703, 32'h0);
      chk(q, 32'h3);
      operating_mode_pins <= 3'h0;
      apb(1'b1, 11'h702, 32'h01);
      repeat (4) @(negedge pclk);
      chk(port_pin_oe[gpf_pkg::P3], 32'hff);
      apb(1'b1, 11'h702, 32'h0);
      repeat (4) @(negedge pclk);
      chk(port_pin_oe[gpf_pkg::P3], 32'h0);
   endtask

   // Main sequence
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      operating_mode_pins = 3'h0;
      port_pin_in = '0;
      bus_data_out = 16'hc3a5;
      bus_data_oe = 1'b1;
      bus_address = 25'h0ff1234;
      bus_address_oe = 1'b1;
      end_of_transfer_out_0 = 1'b1;
      num_errors = 0;
      check_count = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_port();
      t_select();
      t_mode();
      give_verdict();
   end
   // Watchdog well past the expected run length
   initial
   begin
      repeat (5000) @(posedge pclk);
      num_errors++;
      give_verdict();
   end
endmodule
